// ==== shared/fgp_pkg.sv ====
package fgp_pkg;
	localparam int         PORT_WIDTH          = 4;
	localparam int         REG_WIDTH           = 8;
	localparam logic [7:0] STATUS_ADDR         = 8'h03;
	localparam logic [7:0] PORT_ADDR           = 8'h06;
	localparam logic [3:0] DIR_RESET           = 4'hF;
	localparam logic [7:0] OPTION_RESET        = 8'hFF;
	localparam int         OPT_WAKE_BIT        = 7;
	localparam int         OPT_PULLUP_BIT      = 6;
	localparam int         OPT_TSRC_BIT        = 5;
	localparam int         STAT_WAKE_BIT       = 7;
	localparam int         LINE_CLKOUT         = 2;
	localparam int         LINE_MASTER_CLEAR_INPUT           = 3;
	localparam logic [3:0] PULLUP_LINES        = 4'hB;
	localparam logic [3:0] WAKE_LINES          = 4'hB;
endpackage

// ==== logic/fgp_port.sv ====
// How it works
// - port reads return the pin levels whatever the direction
// - port reads eight bits wide, upper four bits read zero
// - line 3 is input only, its driver never enables
// - lines 0, 1, 3 share one pull-up and one wake control
// - line 3 as master clear: no wake, pull-up from configuration only
// - direction-load copies the working register into the direction register
// - direction 1 floats the pin, 0 drives it from its latch
// - direction register write-only, all ones after every reset
// - pins are sampled every cycle through the two sync stages; the source passes levels straight through, holding none
// - output latches clear on reset, then hold until software writes them again
// - fixed pin-function priority per line
// - status wake flag set after pin-change wake reset, else cleared
// - bit set/clear reads pins, modifies one bit, writes all latches
// - writes land at cycle end, reads sample at cycle start
// - timer source select 1 overrides direction on line 2
module fgp_port (
	input  wire logic                          i_clk,
	input  wire logic                          i_resetn,
	input  wire logic                          i_wake_reset,
	input  wire logic [fgp_pkg::PORT_WIDTH-1:0] i_pin,
	input  wire logic [fgp_pkg::REG_WIDTH-1:0]  i_wreg,
	input  wire logic                          i_dir_load,
	input  wire logic                          i_option_load,
	input  wire logic                          i_port_write,
	input  wire logic                          i_port_read,
	input  wire logic                          i_bit_set,
	input  wire logic                          i_bit_clear,
	input  wire logic [2:0]                    i_bit_sel,
	input  wire logic                          i_analog_0,
	input  wire logic                          i_analog_1,
	input  wire logic                          i_clkout_en,
	input  wire logic                          i_clkout_val,
	input  wire logic                          i_master_clear_input_en,
	input  wire logic                          i_cfg_pullup,
	input  wire logic                          i_sleeping,
	output logic [fgp_pkg::REG_WIDTH-1:0]       o_read_data,
	output logic [fgp_pkg::REG_WIDTH-1:0]       o_status_wake,
	output logic [fgp_pkg::PORT_WIDTH-1:0]      o_pin_out,
	output logic [fgp_pkg::PORT_WIDTH-1:0]      o_pin_oe_n,
	output logic [fgp_pkg::PORT_WIDTH-1:0]      o_pullup_en,
	output logic                               o_wake_event,
	output logic [fgp_pkg::REG_WIDTH-1:0]       o_option
);
	import fgp_pkg::*;

	////////////////////////////////////////////////////////////////
	// the logic is written for four lines inside an eight-bit register
	if (PORT_WIDTH != 4) begin : g_width_check
		$error("port logic serves exactly four lines");
	end
	if (REG_WIDTH <= PORT_WIDTH) begin : g_reg_check
		$error("register must be wider than the port");
	end
	if (LINE_MASTER_CLEAR_INPUT >= PORT_WIDTH || LINE_CLKOUT >= PORT_WIDTH) begin : g_line_check
		$error("special line outside the port");
	end

	////////////////////////////////////////////////////////////////
	logic [PORT_WIDTH-1:0] sync1_reg;
	logic [PORT_WIDTH-1:0] sync2_reg;
	logic [PORT_WIDTH-1:0] dir_reg;
	logic [PORT_WIDTH-1:0] dir_next;
	logic [PORT_WIDTH-1:0] latch_reg;
	logic [PORT_WIDTH-1:0] latch_next;
	logic [REG_WIDTH-1:0]  opt_reg;
	logic [REG_WIDTH-1:0]  opt_next;
	logic                  wuf_reg;
	logic                  wuf_next;
	logic [REG_WIDTH-1:0]  rd_reg;
	logic [REG_WIDTH-1:0]  rd_next;
	logic [PORT_WIDTH-1:0] snap_reg;
	logic [PORT_WIDTH-1:0] snap_next;
	logic [PORT_WIDTH-1:0] out_reg;
	logic [PORT_WIDTH-1:0] out_next;
	logic [PORT_WIDTH-1:0] oen_reg;
	logic [PORT_WIDTH-1:0] oen_next;
	logic [PORT_WIDTH-1:0] pu_reg;
	logic [PORT_WIDTH-1:0] pu_next;
	logic                  wev_reg;
	logic                  wev_next;
	logic [PORT_WIDTH-1:0] wake_mask;
	logic [REG_WIDTH-1:0]  rmw;
	logic                  bit_op;
	logic                  pin_sample;

	////////////////////////////////////////////////////////////////
	// only the second stage may be read; the first can be metastable
	// costs two cycles of read latency against the raw pins
	always_ff @(posedge i_clk) begin
		sync1_reg <= i_pin;
		sync2_reg <= sync1_reg;
	end

	////////////////////////////////////////////////////////////////
	// strobes that sample the pins this cycle
	assign bit_op     = i_bit_set || i_bit_clear;
	assign pin_sample = i_port_read || bit_op;

	////////////////////////////////////////////////////////////////
	// register state: direction, latches, option, read data
	always_comb begin
		dir_next   = dir_reg;
		latch_next = latch_reg;
		opt_next   = opt_reg;
		rd_next    = rd_reg;
		// pins read at cycle start, zero-extended above the port
		rmw        = {{(REG_WIDTH-PORT_WIDTH){1'b0}}, sync2_reg};
		if (i_bit_set) begin
			rmw[i_bit_sel] = 1'b1;
		end
		if (i_bit_clear) begin
			rmw[i_bit_sel] = 1'b0;
		end
		if (i_dir_load) begin
			dir_next = i_wreg[PORT_WIDTH-1:0];
		end
		if (i_option_load) begin
			opt_next = i_wreg;
		end
		// a full write outranks a set or clear in the same cycle
		if (i_port_write) begin
			latch_next = i_wreg[PORT_WIDTH-1:0];
		end else if (bit_op) begin
			latch_next = rmw[PORT_WIDTH-1:0];
		end
		if (i_port_read) begin
			rd_next = {{(REG_WIDTH-PORT_WIDTH){1'b0}}, sync2_reg};
		end
		// a set or clear aimed above the port must not leak into the read
		if (bit_op) begin
			rd_next = {{(REG_WIDTH-PORT_WIDTH){1'b0}}, rmw[PORT_WIDTH-1:0]};
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			dir_reg   <= DIR_RESET;
			latch_reg <= '0;
			opt_reg   <= OPTION_RESET;
			rd_reg    <= '0;
		end else begin
			dir_reg   <= dir_next;
			latch_reg <= latch_next;
			opt_reg   <= opt_next;
			rd_reg    <= rd_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// pin ownership, drive and pull-ups
	always_comb begin
		out_next = latch_reg;
		oen_next = dir_reg;
		if (i_analog_0) begin
			oen_next[0] = 1'b1;
		end
		if (i_analog_1) begin
			oen_next[1] = 1'b1;
		end
		if (i_clkout_en) begin
			oen_next[LINE_CLKOUT] = 1'b0;
			out_next[LINE_CLKOUT] = i_clkout_val;
		end else if (opt_reg[OPT_TSRC_BIT]) begin
			oen_next[LINE_CLKOUT] = 1'b1;
		end
		// line 3 can never drive, whatever its direction bit says
		oen_next[LINE_MASTER_CLEAR_INPUT] = 1'b1;
		out_next[LINE_MASTER_CLEAR_INPUT] = 1'b0;
		// shared active-low control covers lines 0, 1 and 3 at once, line 3 only while master clear is off
		pu_next = opt_reg[OPT_PULLUP_BIT] ? '0 : PULLUP_LINES;
		if (i_master_clear_input_en) begin
			pu_next[LINE_MASTER_CLEAR_INPUT] = i_cfg_pullup;
		end
	end

	////////////////////////////////////////////////////////////////
	// wake on change against the last value read
	always_comb begin
		wake_mask = opt_reg[OPT_WAKE_BIT] ? '0 : WAKE_LINES;
		if (i_master_clear_input_en) begin
			wake_mask[LINE_MASTER_CLEAR_INPUT] = 1'b0;
		end
		// snapshot taken by every access that samples the pins
		snap_next = pin_sample ? sync2_reg : snap_reg;
		wev_next  = i_sleeping && |((sync2_reg ^ snap_reg) & wake_mask);
		// flag is only rewritten by reset; the core's reset cause decides it
		wuf_next  = i_resetn ? wuf_reg : i_wake_reset;
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			out_reg  <= '0;
			oen_reg  <= DIR_RESET;
			pu_reg   <= '0;
			snap_reg <= '0;
			wev_reg  <= 1'b0;
		end else begin
			out_reg  <= out_next;
			oen_reg  <= oen_next;
			pu_reg   <= pu_next;
			snap_reg <= snap_next;
			wev_reg  <= wev_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// the flag follows the reset cause, so it is loaded while reset is low
	always_ff @(posedge i_clk) begin
		wuf_reg <= wuf_next;
	end

	////////////////////////////////////////////////////////////////
	assign o_read_data   = rd_reg;
	assign o_status_wake = {wuf_reg, {(REG_WIDTH-1){1'b0}}};
	assign o_pin_out     = out_reg;
	assign o_pin_oe_n    = oen_reg;
	assign o_pullup_en   = pu_reg;
	assign o_wake_event  = wev_reg;
	assign o_option      = opt_reg;
endmodule

// ==== verif/fgp_port_assertions.sv ====
module fgp_chk import fgp_pkg::*; (
	input wire logic       i_clk, i_resetn, i_dir_load, i_option_load,
	input wire logic       i_port_write, i_port_read, i_analog_0, i_clkout_en,
	input wire logic [3:0] i_pin, o_pin_out, o_pin_oe_n, o_pullup_en,
	input wire logic [7:0] i_wreg, o_read_data, o_status_wake, o_option
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// pins must sit still through the two sync stages
	sequence s_calm; $stable(i_pin)[*3] ##0 i_port_read; endsequence
	sequence s_dir; i_dir_load && !i_analog_0 ##1 !i_analog_0; endsequence
	line_three_in_a: assert property (o_pin_oe_n[3]) else $error("line 3 drives");
	upper_zero_a: assert property (o_read_data[7:4] == 4'h0) else $error("upper bits");
	status_low_a: assert property (o_status_wake[6:0] == 7'h00) else $error("status");
	option_load_a: assert property (i_option_load |=> o_option == $past(i_wreg))
		else $error("option");
	port_write_a: assert property (i_port_write |-> ##2 o_pin_out[1:0] == $past(i_wreg[1:0], 2))
		else $error("latch");
	pin_read_a: assert property (s_calm |=> o_read_data[3:0] == $past(i_pin)) else $error("read");
	dir_load_a: assert property (s_dir |=> o_pin_oe_n[0] == $past(i_wreg[0], 2))
		else $error("direction");
	pullup_shared_a: assert property (!o_pullup_en[2] && o_pullup_en[0] == o_pullup_en[1])
		else $error("pullup");
	analog_first_a: assert property (i_analog_0[*3] |-> o_pin_oe_n[0]) else $error("analog");
	clkout_first_a: assert property (i_clkout_en[*3] |-> !o_pin_oe_n[2]) else $error("clkout");
endmodule
bind fgp_port fgp_chk fgp_chk_i (.*);

// ==== verif/fgp_ext.sv ====
module fgp_ext (
	input  wire logic [3:0] i_out,
	input  wire logic [3:0] i_oe_n,
	input  wire logic [3:0] i_ext,
	output logic      [3:0] o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// driven lines show the latch, floating lines pass the outside level straight through, nothing held
	assign o_pin = (~i_oe_n & i_out) | (i_oe_n & i_ext);
endmodule

// ==== verif/testbench.sv ====
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import fgp_pkg::*;
	logic       clk = 0, rstn = 0, wk = 1, an = 0, ck = 0;
	logic [5:0] st = 0;
	logic [2:0] sel = 0;
	logic [3:0] ext = 4'hA, pin, out, oe_n, pu;
	logic [7:0] w = 0, rd, sw, opt;
	int         mismatches = 0, num_checks = 0;
	always #20 clk = ~clk;
	fgp_ext fgp_ext_i (.i_out(out), .i_oe_n(oe_n), .i_ext(ext), .o_pin(pin));
	fgp_port fgp_port_i (.i_clk(clk), .i_resetn(rstn), .i_wake_reset(wk), .i_pin(pin),
		.i_wreg(w), .i_dir_load(st[4]), .i_option_load(st[3]), .i_port_write(st[2]),
		.i_port_read(st[1]), .i_bit_set(st[5]), .i_bit_clear(st[0]), .i_bit_sel(sel),
		.i_analog_0(an), .i_analog_1(1'b0), .i_clkout_en(ck), .i_clkout_val(1'b0),
		.i_master_clear_input_en(1'b0), .i_cfg_pullup(1'b0), .i_sleeping(1'b0), .o_read_data(rd),
		.o_status_wake(sw), .o_pin_out(out), .o_pin_oe_n(oe_n), .o_pullup_en(pu),
		.o_wake_event(), .o_option(opt));
	task chk(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task op(input logic [5:0] s, input logic [7:0] v);
		@(posedge clk) #1 st = s;
		w = v;
		idle(1);
		st = 0;
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task t_reset(input logic cause);
		rstn = 0;
		wk = cause;
		idle(4);
		rstn = 1;
		chk(sw, {cause, 7'h00});
		chk({4'h0, oe_n}, {4'h0, DIR_RESET});
		chk(opt, OPTION_RESET);
	endtask
	task t_write_read;
		op(5'h10, 8'h08);
		op(5'h04, 8'h05);
		idle(3);
		chk({5'h00, out[2:0]}, 8'h05);
		chk({4'h0, oe_n}, 8'h0C);
		op(5'h02, 8'h00);
		idle(1);
		chk(rd, 8'h09);
	endtask
	task t_rmw;
		op(5'h10, 8'h09);
		idle(3);
		sel = 3'h2;
		op(5'h01, 8'h00);
		idle(1);
		chk(rd, 8'h08);
		op(5'h10, 8'h00);
		idle(2);
		chk({5'h00, out[2:0]}, 8'h00);
		sel = 3'h0;
		op(6'h20, 8'h00);
		idle(1);
		chk(rd, 8'h09);
		idle(2);
		chk({5'h00, out[2:0]}, 8'h01);
		sel = 3'h5;
		op(6'h20, 8'h00);
		idle(1);
		chk(rd, 8'h09);
	endtask
	task t_option;
		op(5'h08, 8'h3F);
		idle(2);
		chk(opt, 8'h3F);
		chk({4'h0, pu}, {4'h0, PULLUP_LINES});
		chk({7'h00, oe_n[2]}, 8'h01);
		op(5'h08, 8'h1F);
		idle(2);
		chk({7'h00, oe_n[2]}, 8'h00);
		an = 1;
		ck = 1;
		idle(4);
		chk({5'h00, oe_n[2:0]}, 8'h01);
	endtask
	initial begin
		t_reset(1'b1);
		t_reset(1'b0);
		t_write_read;
		t_rmw;
		t_option;
		give_verdict;
	end
	initial begin
		#20000;
		mismatches++;
		give_verdict;
	end
endmodule
